// ==== rtl/serial_rx_dma_pkg.sv ====
// Constants for the serial receive DMA channel.
// Assumes one system clock; serial clock and data come from pins.
//
// Operation
// - Channel stays idle until software sets the channel enable bit.
// - Software configures, then sets start; channel enters trigger-wait.
// - Each serial transfer-end request in trigger-wait copies serial data into RAM buffer.
// - At the programmed count, clear start, leave wait, raise done interrupt.
// - Direction is special-function register to RAM, serial-event triggered.
// - Serial unit is slave receiver; external master drives clock and data.
// - Each transfer moves exactly one eight-bit unit.
// - Source address is fixed at the serial data register location.
// - Receive 8 bits, LSB first, phase type 1, external serial clock.
package serial_rx_dma_pkg;

    // ------------------------------------------------------------
    // Widths and constants
    // ------------------------------------------------------------
    localparam int             DATA_W      = 8;
    localparam int             ADDR_W      = 20;
    localparam int             CNT_W       = 10;
    localparam int             BIT_CNT_W   = 3;
    localparam logic [ADDR_W-1:0] SRC_ADDR = 20'hFFF10;
    localparam logic [CNT_W-1:0]  DEF_COUNT = 10'h005;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------
    // Channel states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_MOVE = 3'b100
    } dma_state_t;

endpackage : serial_rx_dma_pkg

// ==== rtl/serial_rx_dma_channel.sv ====
// Serial slave receiver with a one-channel DMA into RAM.
// Assumes a write-only RAM port that accepts a write every cycle.
`timescale 1ns/1ps
module serial_rx_dma_channel
    import serial_rx_dma_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Serial pins
    input  wire logic              serial_clock_input,
    input  wire logic              serial_data_input,
    // Control
    input  wire logic              dma_channel_enable,
    input  wire logic              dma_start_set,
    input  wire logic [ADDR_W-1:0] dma_dest_addr,
    input  wire logic [CNT_W-1:0]  dma_count,
    // Status
    output logic                   dma_transfer_start,
    output logic                   dma_done_interrupt,
    output logic                   serial_xfer_end_request,
    output logic [DATA_W-1:0]      serial_data_register,
    output logic [CNT_W-1:0]       dma_remaining,
    // RAM write port
    output logic                   ram_we,
    output logic [ADDR_W-1:0]      ram_addr,
    output logic [DATA_W-1:0]      ram_wdata,
    output logic [ADDR_W-1:0]      ram_src_addr
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sckSync;
    logic [1:0] sdiSync;
    logic       sckPrev;
    logic [1:0] next_sckSync;
    logic [1:0] next_sdiSync;

    always_comb
    begin
        next_sckSync = {sckSync[0], serial_clock_input};
        next_sdiSync = {sdiSync[0], serial_data_input};
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sckSync <= 2'h0;
            sdiSync <= 2'h0;
            sckPrev <= 1'h0;
        end
        else
        begin
            sckSync <= next_sckSync;
            sdiSync <= next_sdiSync;
            sckPrev <= sckSync[1];
        end
    end

    // ------------------------------------------------------------
    // Serial receiver
    // ------------------------------------------------------------
    logic [DATA_W-1:0]    shiftReg;
    logic [BIT_CNT_W-1:0] bitCnt;
    logic [DATA_W-1:0]    next_shiftReg;
    logic [BIT_CNT_W-1:0] next_bitCnt;
    logic [DATA_W-1:0]    next_sdr;
    logic                 next_xferEnd;
    logic                 sampleEdge;

    // Shift one serial bit in at the top, LSB first
    function automatic logic [DATA_W-1:0] shift_in
    (
        input logic [DATA_W-1:0] cur,
        input logic              bitIn
    );
        return {bitIn, cur[DATA_W-1:1]};
    endfunction : shift_in

    always_comb
    begin
        // Type 1 phase: data sampled on rising serial clock
        sampleEdge    = sckSync[1] & ~sckPrev;
        next_shiftReg = shiftReg;
        next_bitCnt   = bitCnt;
        next_sdr      = serial_data_register;
        next_xferEnd  = 1'b0;
        if (sampleEdge)
        begin
            // LSB first: shift in from the top
            next_shiftReg = shift_in(shiftReg, sdiSync[1]);
            next_bitCnt   = bitCnt + 3'h1;
            if (bitCnt == LAST_BIT)
            begin
                next_sdr     = shift_in(shiftReg, sdiSync[1]);
                next_xferEnd = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            shiftReg                <= 8'h00;
            bitCnt                  <= 3'h0;
            serial_data_register    <= 8'h00;
            serial_xfer_end_request <= 1'b0;
        end
        else
        begin
            shiftReg                <= next_shiftReg;
            bitCnt                  <= next_bitCnt;
            serial_data_register    <= next_sdr;
            serial_xfer_end_request <= next_xferEnd;
        end
    end

    // ------------------------------------------------------------
    // DMA channel
    // ------------------------------------------------------------
    dma_state_t        state;
    dma_state_t        next_state;
    logic [ADDR_W-1:0] destPtr;
    logic [ADDR_W-1:0] next_destPtr;
    logic [CNT_W-1:0]  next_remaining;
    logic              next_start;
    logic              next_done;
    logic              next_we;
    logic [ADDR_W-1:0] next_ramAddr;
    logic [DATA_W-1:0] next_wdata;

    always_comb
    begin
        next_state     = state;
        next_destPtr   = destPtr;
        next_remaining = dma_remaining;
        next_start     = dma_transfer_start;
        next_done      = 1'b0;
        next_we        = 1'b0;
        next_ramAddr   = ram_addr;
        next_wdata     = ram_wdata;
        case (state)
            ST_IDLE:
            begin
                if (dma_channel_enable && dma_start_set)
                begin
                    next_destPtr   = dma_dest_addr;
                    next_remaining = dma_count;
                    next_start     = 1'b1;
                    next_state     = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (!dma_channel_enable)
                begin
                    next_start = 1'b0;
                    next_state = ST_IDLE;
                end
                else if (serial_xfer_end_request)
                begin
                    // SFR source to RAM, one byte per trigger
                    next_we      = 1'b1;
                    next_ramAddr = destPtr;
                    next_wdata   = serial_data_register;
                    next_destPtr = destPtr + 20'h00001;
                    next_remaining = dma_remaining - 10'h001;
                    next_state   = ST_MOVE;
                end
            end
            ST_MOVE:
            begin
                if (dma_remaining == 10'h000)
                begin
                    next_start = 1'b0;
                    next_done  = 1'b1;
                    next_state = ST_IDLE;
                end
                else
                begin
                    next_state = ST_WAIT;
                end
            end
            default:
            begin
                next_start = 1'b0;
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state              <= ST_IDLE;
            destPtr            <= 20'h00000;
            dma_remaining      <= 10'h000;
            dma_transfer_start <= 1'b0;
            dma_done_interrupt <= 1'b0;
            ram_we             <= 1'b0;
            ram_addr           <= 20'h00000;
            ram_wdata          <= 8'h00;
            ram_src_addr       <= SRC_ADDR;
        end
        else
        begin
            state              <= next_state;
            destPtr            <= next_destPtr;
            dma_remaining      <= next_remaining;
            dma_transfer_start <= next_start;
            dma_done_interrupt <= next_done;
            ram_we             <= next_we;
            ram_addr           <= next_ramAddr;
            ram_wdata          <= next_wdata;
            ram_src_addr       <= SRC_ADDR;
        end
    end

endmodule : serial_rx_dma_channel

// ==== verif/serial_master_model.sv ====
// Far-side serial master: drives link clock and data.
// Assumes the receiver samples data on rising clock.
`timescale 1ns/1ps
module serial_master_model
(
    // Serial pins
    output logic serialClock,
    output logic serialData
);
    initial serialClock = 1'b0;
    initial serialData = 1'b0;
    task automatic send_byte(input logic [7:0] value);
        for (int i = 0; i < 8; i++)
        begin
            serialData = value[i];
            #200 serialClock = 1'b1;
            #200 serialClock = 1'b0;
        end
        serialData = ~value[7];
    endtask : send_byte
endmodule : serial_master_model

// ==== verif/serial_rx_dma_channel_monitor.sv ====
// Assertions on the channel ports.
// Assumes binding to serial_rx_dma_channel.
`timescale 1ns/1ps
module serial_rx_dma_channel_monitor
    import serial_rx_dma_pkg::*;
(
    // Watched ports
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic              dma_channel_enable,
    input wire logic              dma_start_set,
    input wire logic [ADDR_W-1:0] dma_dest_addr,
    input wire logic [CNT_W-1:0]  dma_count,
    input wire logic              dma_transfer_start,
    input wire logic              dma_done_interrupt,
    input wire logic              serial_xfer_end_request,
    input wire logic [DATA_W-1:0] serial_data_register,
    input wire logic [CNT_W-1:0]  dma_remaining,
    input wire logic              ram_we,
    input wire logic [ADDR_W-1:0] ram_addr,
    input wire logic [DATA_W-1:0] ram_wdata,
    input wire logic [ADDR_W-1:0] ram_src_addr
);
    default clocking ck @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_last; ram_we && dma_remaining == '0; endsequence
    sequence s_done; dma_done_interrupt && !dma_transfer_start; endsequence
    a_src_fixed: assert property (ram_src_addr == SRC_ADDR)
        else $error("source address moved");
    a_idle_quiet: assert property (ram_we |-> dma_transfer_start)
        else $error("write while inactive");
    a_start_cause: assert property ($rose(dma_transfer_start) |->
        $past(dma_channel_enable && dma_start_set)) else $error("bad start");
    a_take_write: assert property (serial_xfer_end_request &&
        dma_transfer_start |=> ram_we && ram_wdata == serial_data_register)
        else $error("request not moved");
    a_write_once: assert property (ram_we |=> !ram_we)
        else $error("write longer than one cycle");
    a_dest_step: assert property (ram_we |-> ram_addr ==
        dma_dest_addr + ADDR_W'(dma_count - dma_remaining - 1'b1))
        else $error("wrong destination");
    a_last_done: assert property (s_last |=> s_done)
        else $error("no completion");
    a_done_cause: assert property (dma_done_interrupt |->
        $past(ram_we) && $past(dma_remaining) == '0) else $error("early done");
    a_req_pulse: assert property (serial_xfer_end_request |=>
        !serial_xfer_end_request) else $error("request held too long");
endmodule : serial_rx_dma_channel_monitor

// ==== verif/testbench.sv ====
// Bench for the serial receive DMA channel.
// Assumes master model and monitor compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module testbench
    import serial_rx_dma_pkg::*;
;
    typedef struct packed {logic [7:0] b; logic [CNT_W-1:0] rem;} row_t;
    logic              sys_clk = 1'b0;
    logic              rst = 1'b1;
    logic              dma_channel_enable = 1'b0;
    logic              dma_start_set = 1'b0;
    logic [ADDR_W-1:0] dma_dest_addr = 20'h00200;
    logic [CNT_W-1:0]  dma_count = DEF_COUNT;
    logic              serial_clock_input, serial_data_input, ram_we;
    logic              dma_transfer_start, dma_done_interrupt;
    logic              serial_xfer_end_request;
    logic [DATA_W-1:0] serial_data_register, ram_wdata;
    logic [CNT_W-1:0]  dma_remaining;
    logic [ADDR_W-1:0] ram_addr, ram_src_addr;
    int                n_errors = 0, n_compared = 0, nWrites = 0, nDone = 0;
    int                nReq = 0;
    row_t              rows [5] = '{'{8'h01, 10'h004}, '{8'h80, 10'h003},
        '{8'h3A, 10'h002}, '{8'hC5, 10'h001}, '{8'hFF, 10'h000}};
    serial_master_model master (.serialClock(serial_clock_input),
        .serialData(serial_data_input));
    serial_rx_dma_channel dut (.sys_clk, .rst, .serial_clock_input,
        .serial_data_input, .dma_channel_enable, .dma_start_set,
        .dma_dest_addr, .dma_count, .dma_transfer_start, .dma_done_interrupt,
        .serial_xfer_end_request, .serial_data_register, .dma_remaining,
        .ram_we, .ram_addr, .ram_wdata, .ram_src_addr);
    always #25 sys_clk = ~sys_clk;
    always @(negedge sys_clk)
    begin
        nWrites <= nWrites + int'(ram_we === 1'b1);
        nDone   <= nDone + int'(dma_done_interrupt === 1'b1);
        nReq    <= nReq + int'(serial_xfer_end_request === 1'b1);
    end
    task automatic wait_for(input int e);
        for (int k = 0; k < 40 && nWrites < e; k++)
            @(negedge sys_clk);
        if (nWrites < e)
            n_errors++;
    endtask : wait_for
    task automatic run_block(input logic [ADDR_W-1:0] base);
        int w;
        int d;
        w = nWrites;
        d = nDone;
        dma_dest_addr = base;
        {dma_channel_enable, dma_start_set} = 2'b11;
        @(negedge sys_clk);
        dma_start_set = 1'b0;
        `CHK(dma_transfer_start, 1'b1)
        foreach (rows[i])
        begin
            master.send_byte(rows[i].b);
            wait_for(w + i + 1);
            `CHK(ram_wdata, rows[i].b)
            `CHK(ram_addr, base + ADDR_W'(i))
            `CHK(dma_remaining, rows[i].rem)
        end
        @(negedge sys_clk);
        `CHK(nDone, d + 1)
        `CHK(dma_transfer_start, 1'b0)
        $display("test block done");
    endtask : run_block
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (2) @(negedge sys_clk);
        `CHK(ram_src_addr, SRC_ADDR)
        `CHK(dma_transfer_start, 1'b0)
        rst = 1'b0;
        dma_start_set = 1'b1;
        master.send_byte(8'h5A);
        repeat (8) @(negedge sys_clk);
        `CHK(serial_data_register, 8'h5A)
        `CHK(nWrites, 0)
        `CHK(nReq, 1)
        $display("test idle done");
        run_block(20'h00200);
        run_block(20'h00340);
        {dma_channel_enable, dma_start_set} = 2'b11;
        @(negedge sys_clk);
        dma_start_set = 1'b0;
        master.send_byte(8'h77);
        wait_for(11);
        dma_channel_enable = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK(dma_transfer_start, 1'b0)
        `CHK(nDone, 2)
        $display("test abort done");
        {dma_channel_enable, dma_start_set} = 2'b11;
        @(negedge sys_clk);
        dma_start_set = 1'b0;
        master.send_byte(8'h42);
        wait_for(12);
        rst = 1'b1;
        @(negedge sys_clk);
        `CHK(dma_transfer_start, 1'b0)
        `CHK(dma_remaining, 10'h000)
        `CHK(ram_src_addr, SRC_ADDR)
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK(dma_transfer_start, 1'b0)
        dma_start_set = 1'b1;
        @(negedge sys_clk);
        dma_start_set = 1'b0;
        `CHK(dma_transfer_start, 1'b1)
        `CHK(dma_remaining, DEF_COUNT)
        master.send_byte(8'hA5);
        wait_for(13);
        `CHK(ram_wdata, 8'hA5)
        `CHK(ram_addr, 20'h00340)
        `CHK(dma_remaining, 10'h004)
        dma_channel_enable = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK(dma_transfer_start, 1'b0)
        `CHK(nDone, 2)
        $display("test reset done");
        end_of_test();
    end
    initial
    begin
        #200000;
        n_errors++;
        end_of_test();
    end
endmodule : testbench
bind serial_rx_dma_channel serial_rx_dma_channel_monitor mon (.sys_clk,
    .rst, .dma_channel_enable, .dma_start_set, .dma_dest_addr, .dma_count,
    .dma_transfer_start, .dma_done_interrupt, .serial_xfer_end_request,
    .serial_data_register, .dma_remaining, .ram_we, .ram_addr, .ram_wdata,
    .ram_src_addr);
